// ### shared/field_eval_defs.svh
// constants of the field evaluation and output switch block
`ifndef FIELD_EVAL_DEFS_SVH
`define FIELD_EVAL_DEFS_SVH

// build variant: 0 = small (8 fields, 4 outputs), 1 = large
`define FE_LARGE_VARIANT   0
`define FE_NUM_FIELDS_S    8
`define FE_NUM_OUTS_S      4
`define FE_NUM_FIELDS_L    128
`define FE_NUM_OUTS_L      8
`define FE_NUM_SETS        8
`define FE_NUM_CASES       8
`define FE_CASE_W          3
`define FE_SET_W           3

// configuration word layout, one word per field
`define FE_CFG_TYPE_LSB    0
`define FE_CFG_SET_LSB     2
`define FE_CFG_OUT_LSB     5
`define FE_CFG_W           13
// case map word: bit per field set
`define FE_CASE_MAP_W      8

// reset values
`define FE_OUT_RESET       1'b0

`endif

// ### shared/field_eval_pkg.sv
// types of the field evaluation and output switch block
package field_eval_pkg;

    typedef enum logic [1:0] {
        FT_PROTECT   = 2'b00,
        FT_REF_CONT  = 2'b01,
        FT_CONT_DET  = 2'b10,
        FT_WARN      = 2'b11
    } field_kind_type;

    typedef enum logic [1:0] {
        ST_LOAD_FIELDS = 2'b00,
        ST_LOAD_CASES  = 2'b01,
        ST_WAIT_CASE   = 2'b10,
        ST_MONITOR     = 2'b11
    } eval_state_type;

endpackage

// ### hdl/field_eval_core.sv
// per-field evaluation: one instance per field, all run in parallel
`timescale 1ns/10ps
`include "field_eval_defs.svh"

module field_eval_core
    import field_eval_pkg::*;
#(
    parameter int NOUTS = 4
) (
    input  wire logic [`FE_CFG_W-1:0]      i_cfg,
    input  wire logic [`FE_CASE_MAP_W-1:0] i_active_sets,
    input  wire logic                      i_hit,
    output logic      [NOUTS-1:0]          o_off_mask,
    output logic                           o_off_all,
    output logic                           o_warn
);

    field_kind_type           kind;
    logic [`FE_SET_W-1:0]     set_idx;
    logic [NOUTS-1:0]         out_map;
    logic                     active;

    // decode of the configuration word
    always_comb begin
        kind    = field_kind_type'(i_cfg[`FE_CFG_TYPE_LSB +: 2]);
        set_idx = i_cfg[`FE_CFG_SET_LSB +: `FE_SET_W];
        out_map = i_cfg[`FE_CFG_OUT_LSB +: NOUTS];
        active  = i_active_sets[set_idx];
    end

    // effect of a hit, by field kind
    always_comb begin
        o_off_mask = '0;
        o_off_all  = 1'b0;
        o_warn     = 1'b0;
        if (active && i_hit) begin
            case (kind)
                // R1 protective field off
                FT_PROTECT:  o_off_mask = out_map;
                // R2 reference contour all off
                FT_REF_CONT: o_off_all  = 1'b1;
                // R3 contour detection own outputs
                FT_CONT_DET: o_off_mask = out_map;
                // R4 warning never switches off
                default:     o_warn     = 1'b1;
            endcase
        end
    end

endmodule

// ### hdl/field_eval_output_switch.sv
// field evaluation and safety output switching of a laser scanner
//
// Behaviour
// R1 - An object in an active protective field turns off its own outputs.
// R2 - A reference contour mismatch turns off every safety output.
// R3 - A contour detection mismatch turns off only its outputs in this case.
// R4 - A warning field drives only the warning indication, never an output.
// R5 - All fields of an active field set are evaluated in parallel each scan.
// R6 - Only the field sets mapped to the selected case are evaluated.
// R7 - A change of the case signal switches to the case mapped to it.
// R8 - Each field set of one case steers its own outputs independently.
// R9 - The whole configuration is loaded from external memory at power-up.
// R10 - Field and output counts are a build choice: 8/4 or 128/8.
// R11 - Outputs stay off until loaded and a valid case is selected.
`timescale 1ns/10ps
`include "field_eval_defs.svh"

module field_eval_output_switch
    import field_eval_pkg::*;
#(
    // R10 variant sizes
    parameter int NFIELDS = (`FE_LARGE_VARIANT != 0) ?
                            `FE_NUM_FIELDS_L : `FE_NUM_FIELDS_S,
    parameter int NOUTS   = (`FE_LARGE_VARIANT != 0) ?
                            `FE_NUM_OUTS_L : `FE_NUM_OUTS_S,
    parameter int AW      = $clog2(NFIELDS + `FE_NUM_CASES)
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rstn,
    // configuration memory read port
    output logic                          o_cfg_rd,
    output logic      [AW-1:0]            o_cfg_addr,
    input  wire logic                     i_cfg_valid,
    input  wire logic [`FE_CFG_W-1:0]     i_cfg_data,
    // monitoring case from the controller
    input  wire logic [`FE_CASE_W-1:0]    i_case_sel,
    input  wire logic                     i_case_valid,
    // per-field results of the current scan
    input  wire logic                     i_scan_done,
    input  wire logic [NFIELDS-1:0]       i_field_hit,
    // results
    output logic      [NOUTS-1:0]         o_safe_out,
    output logic                          o_warn,
    output logic                          o_cfg_loaded,
    output logic      [`FE_CASE_W-1:0]    o_active_case
);

    localparam logic [AW-1:0] LAST_FIELD = AW'(NFIELDS - 1);
    localparam logic [AW-1:0] LAST_ADDR  = AW'(NFIELDS + `FE_NUM_CASES - 1);
    localparam int            FW         = $clog2(NFIELDS);
    localparam int            CW         = `FE_CASE_W;

    eval_state_type                   state_ff;
    logic [AW-1:0]                    addr_ff;
    logic                             rd_pend_ff;
    logic [`FE_CFG_W-1:0]             field_cfg_ff [NFIELDS];
    logic [`FE_CASE_MAP_W-1:0]        case_map_ff [`FE_NUM_CASES];
    logic [`FE_CASE_W-1:0]            case_ff;
    logic [NOUTS-1:0]                 out_ff;
    logic                             warn_ff;
    logic                             load_done_ff;

    logic [NOUTS-1:0]                 off_mask [NFIELDS];
    logic [NFIELDS-1:0]               off_all;
    logic [NFIELDS-1:0]               warn_vec;
    logic [NOUTS-1:0]                 nxt_out;
    logic                             nxt_warn;
    logic [`FE_CASE_MAP_W-1:0]        active_sets;

    // a case selector value is usable only if its map names any field set
    function automatic logic case_ok(input logic [`FE_CASE_MAP_W-1:0] map);
        case_ok = |map;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // power-up load sequencer

    assign o_cfg_rd     = (state_ff == ST_LOAD_FIELDS ||
                           state_ff == ST_LOAD_CASES) && !rd_pend_ff;
    assign o_cfg_addr   = addr_ff;
    assign o_cfg_loaded = load_done_ff;

    // R9 load before monitoring
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff     <= ST_LOAD_FIELDS;
            addr_ff      <= '0;
            rd_pend_ff   <= 1'b0;
            load_done_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_LOAD_FIELDS, ST_LOAD_CASES: begin
                    if (o_cfg_rd) begin
                        rd_pend_ff <= 1'b1;
                    end else if (i_cfg_valid) begin
                        rd_pend_ff <= 1'b0;
                        addr_ff    <= addr_ff + AW'(1);
                        if (addr_ff == LAST_FIELD) begin
                            state_ff <= ST_LOAD_CASES;
                        end
                        if (addr_ff == LAST_ADDR) begin
                            state_ff     <= ST_WAIT_CASE;
                            load_done_ff <= 1'b1;
                        end
                    end
                end
                ST_WAIT_CASE: begin
                    if (i_case_valid && case_ok(case_map_ff[i_case_sel])) begin
                        state_ff <= ST_MONITOR;
                    end
                end
                default: begin
                    // losing a valid case drops back to a safe wait
                    if (!i_case_valid ||
                        !case_ok(case_map_ff[i_case_sel])) begin
                        state_ff <= ST_WAIT_CASE;
                    end
                end
            endcase
        end
    end

    // configuration storage, written only while loading
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NFIELDS; i++) begin
                field_cfg_ff[i] <= '0;
            end
            for (int j = 0; j < `FE_NUM_CASES; j++) begin
                case_map_ff[j] <= '0;
            end
        end else if (rd_pend_ff && i_cfg_valid) begin
            if (state_ff == ST_LOAD_FIELDS) begin
                field_cfg_ff[addr_ff[FW-1:0]] <= i_cfg_data;
            end else if (state_ff == ST_LOAD_CASES) begin
                // offset of a map word, cut to the case index width
                case_map_ff[CW'(addr_ff - AW'(NFIELDS))] <=
                    i_cfg_data[`FE_CASE_MAP_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitoring case selection

    // R7 follow the case signal
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            case_ff <= '0;
        end else if (load_done_ff && i_case_valid) begin
            case_ff <= i_case_sel;
        end
    end
    assign o_active_case = case_ff;

    // R6 only the mapped field sets
    assign active_sets = (state_ff == ST_MONITOR) ? case_map_ff[case_ff] : '0;

    ////////////////////////////////////////////////////////////////////////
    // parallel field evaluation

    // R5 every field in parallel
    for (genvar g = 0; g < NFIELDS; g++) begin : g_field
        field_eval_core #(
            .NOUTS (NOUTS)
        ) u_core (
            .i_cfg         (field_cfg_ff[g]),
            .i_active_sets (active_sets),
            .i_hit         (i_field_hit[g]),
            .o_off_mask    (off_mask[g]),
            .o_off_all     (off_all[g]),
            .o_warn        (warn_vec[g])
        );
    end

    // R8 per-set output groups combine by OR of off requests
    always_comb begin
        nxt_out = '1;
        for (int k = 0; k < NFIELDS; k++) begin
            nxt_out = nxt_out & ~off_mask[k];
        end
        // R2 any reference mismatch
        if (|off_all) begin
            nxt_out = '0;
        end
        // R4 warning kept apart
        nxt_warn = |warn_vec;
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers; updated once per scan result

    // R11 off until ready
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_ff  <= {NOUTS{`FE_OUT_RESET}};
            warn_ff <= 1'b0;
        // a dropped case request switches off at this very edge, so no
        // scan result of the old case slips out while the state catches up
        end else if (state_ff != ST_MONITOR || !i_case_valid) begin
            out_ff  <= {NOUTS{`FE_OUT_RESET}};
            warn_ff <= 1'b0;
        end else if (i_scan_done) begin
            out_ff  <= nxt_out;
            warn_ff <= nxt_warn;
        end
    end
    assign o_safe_out = out_ff;
    assign o_warn     = warn_ff;

endmodule

// ### sim/field_eval_cfg_mem.sv
// model of the external configuration memory behind the connector module
`timescale 1ns/10ps
`include "field_eval_defs.svh"

module field_eval_cfg_mem #(
    parameter int AW = 4
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_cfg_rd,
    input  wire logic [AW-1:0]        i_cfg_addr,
    output logic                      o_cfg_valid,
    output logic      [`FE_CFG_W-1:0] o_cfg_data
);
    logic [`FE_CFG_W-1:0] mem [16];
    logic                 busy_ff;
    logic [1:0]           wait_ff;
    logic [AW-1:0]        addr_ff;

    // field words then case maps; set 4 is in case 4 and 5 only
    initial begin
        mem = '{13'h0020, 13'h0005, 13'h008A, 13'h01E3, 13'h004C, 13'h0110,
                13'h010E, 13'h000B, 13'h0000, 13'h0001, 13'h000D, 13'h0002,
                13'h0010, 13'h001F, 13'h0005, 13'h0008};
    end

    ////////////////////////////////////////////////////////////////////////
    // answer reads; the low address bits pick a 0..3 cycle delay so
    // both prompt and slow answers occur; idle data toggles, never holds
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_ff     <= 1'b0;
            wait_ff     <= 2'h0;
            addr_ff     <= '0;
            o_cfg_valid <= 1'b0;
            o_cfg_data  <= '0;
        end else begin
            o_cfg_valid <= 1'b0;
            o_cfg_data  <= ~o_cfg_data;
            if (i_cfg_rd && !busy_ff) begin
                busy_ff <= 1'b1;
                addr_ff <= i_cfg_addr;
                wait_ff <= i_cfg_addr[1:0];
            end else if (busy_ff && wait_ff != 2'h0) begin
                wait_ff <= wait_ff - 2'h1;
            end else if (busy_ff) begin
                busy_ff     <= 1'b0;
                o_cfg_valid <= 1'b1;
                o_cfg_data  <= mem[addr_ff];
            end
        end
    end
endmodule

// ### sim/field_eval_output_switch_checker.sv
// port assertions of the field evaluation and output switch
`timescale 1ns/10ps
`include "field_eval_defs.svh"

module field_eval_output_switch_checker #(
    parameter int NOUTS = 4,
    parameter int AW    = 4
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rstn,
    input wire logic                  o_cfg_rd,
    input wire logic [AW-1:0]         o_cfg_addr,
    input wire logic                  i_cfg_valid,
    input wire logic [`FE_CASE_W-1:0] i_case_sel,
    input wire logic                  i_case_valid,
    input wire logic                  i_scan_done,
    input wire logic [NOUTS-1:0]      o_safe_out,
    input wire logic                  o_warn,
    input wire logic                  o_cfg_loaded,
    input wire logic [`FE_CASE_W-1:0] o_active_case
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    chk_off_unloaded: assert property (
        !o_cfg_loaded |-> o_safe_out == '0)
        else $error("output on before load");
    chk_warn_unloaded: assert property (!o_cfg_loaded |-> !o_warn)
        else $error("warning before load");
    chk_no_case_off: assert property (
        !i_case_valid |=> o_safe_out == '0)
        else $error("output on without case");
    chk_case_latch: assert property (o_cfg_loaded && i_case_valid |=>
        o_active_case == $past(i_case_sel)) else $error("case not latched");
    chk_hold_no_scan: assert property ((i_case_valid && !i_scan_done &&
        $stable(i_case_sel))[*4] |=> $stable(o_safe_out))
        else $error("outputs moved without scan");
    chk_rd_one_cycle: assert property (o_cfg_rd |=> !o_cfg_rd)
        else $error("read held");
    chk_addr_hold: assert property (!o_cfg_loaded && !o_cfg_rd &&
        !i_cfg_valid |=> $stable(o_cfg_addr)) else $error("address moved");
    chk_addr_step: assert property (!o_cfg_loaded && i_cfg_valid &&
        !o_cfg_rd |=> o_cfg_loaded || o_cfg_addr == $past(o_cfg_addr) + 1'b1)
        else $error("address skipped");
    chk_warn_cause: assert property (
        $rose(o_warn) |-> $past(i_scan_done))
        else $error("warning without scan");

    cover property ($rose(o_cfg_loaded));
    cover property (i_scan_done ##1 o_warn);
    cover property (i_scan_done ##1 o_safe_out == '1);
endmodule

bind field_eval_output_switch field_eval_output_switch_checker #(
    .NOUTS(NOUTS), .AW(AW)) field_eval_output_switch_checker_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .o_cfg_rd(o_cfg_rd),
    .o_cfg_addr(o_cfg_addr), .i_cfg_valid(i_cfg_valid),
    .i_case_sel(i_case_sel), .i_case_valid(i_case_valid),
    .i_scan_done(i_scan_done), .o_safe_out(o_safe_out), .o_warn(o_warn),
    .o_cfg_loaded(o_cfg_loaded), .o_active_case(o_active_case));

// ### sim/field_eval_output_switch_tb_top.sv
// self-checking bench of the field evaluation and output switch
`timescale 1ns/10ps
`include "field_eval_defs.svh"

module field_eval_output_switch_tb_top import field_eval_pkg::*;;
    logic        clk = 0, rstn = 0, rd, valid, sd = 0, cv = 0, ld, warn;
    logic        sd_seen = 0;
    logic [3:0]  addr, outs;
    logic [12:0] data;
    logic [2:0]  sel = 0, acase;
    logic [7:0]  hits = 0;
    logic [31:0] s = 3187;
    logic [4:0]  expq [$];
    int          failures = 0, checked = 0;

    field_eval_output_switch #(.NFIELDS(8), .NOUTS(4))
        field_eval_output_switch_inst (.i_core_clk(clk), .i_rstn(rstn),
        .o_cfg_rd(rd), .o_cfg_addr(addr), .i_cfg_valid(valid),
        .i_cfg_data(data), .i_case_sel(sel), .i_case_valid(cv),
        .i_scan_done(sd), .i_field_hit(hits), .o_safe_out(outs),
        .o_warn(warn), .o_cfg_loaded(ld), .o_active_case(acase));
    field_eval_cfg_mem #(.AW(4)) field_eval_cfg_mem_inst (.i_core_clk(clk),
        .i_rstn(rstn), .i_cfg_rd(rd), .i_cfg_addr(addr), .o_cfg_valid(valid),
        .o_cfg_data(data));

    initial forever #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // expected warning and outputs from the stored configuration
    function automatic logic [4:0] expect_res(logic [2:0] c, logic [7:0] h,
                                              logic v);
        logic [12:0] w;
        logic [7:0]  m;
        logic [3:0]  off;
        logic        all, wn;
        m = field_eval_cfg_mem_inst.mem[8 + c][7:0];
        off = 4'h0;
        all = 0;
        wn = 0;
        for (int f = 0; f < 8; f++) begin
            w = field_eval_cfg_mem_inst.mem[f];
            if (m[w[4:2]] && h[f]) begin
                if (w[1:0] == FT_REF_CONT) all = 1;
                else if (w[1:0] == FT_WARN) wn = 1;
                else off |= w[8:5];
            end
        end
        if (!v || m == 8'h00) return 5'h00;
        return {wn, all ? 4'h0 : ~off};
    endfunction

    function automatic logic [7:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[7:0];
    endfunction

    task automatic chk(string n, logic [4:0] seen, logic [4:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", n, exp, seen);
        end
    endtask

    // back-to-back scans: the pulse stays high across calls
    task automatic scan(logic [7:0] h);
        @(negedge clk);
        sd = 1;
        hits = h;
        expq.push_back(expect_res(sel, h, cv));
    endtask

    task automatic set_case(logic v, logic [2:0] c);
        @(negedge clk);
        sd = 0;
        cv = v;
        sel = c;
        // hits wander with no scan flagged; the outputs must not follow
        hits = rnd();
        repeat (5) @(negedge clk);
        if (v) chk("case", {2'b00, acase}, {2'b00, c});
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // results land one edge after the scan pulse
    always @(posedge clk) sd_seen <= sd;
    always @(negedge clk) if (sd_seen && expq.size() > 0)
        chk("outputs", {warn, outs}, expq.pop_front());

    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        for (int i = 0; i < 300 && ld !== 1'b1; i++) @(negedge clk);
        chk("loaded", {4'h0, ld}, 5'h01);
        scan(8'hff);
        for (int c = 0; c < 8; c++) begin
            set_case(1, c[2:0]);
            for (int j = 0; j < 6; j++) scan(j == 0 ? 8'h00 : rnd());
        end
        set_case(0, 3'h2);
        scan(8'h00);
        repeat (3) @(negedge clk);
        close_out();
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #100000;
        failures++;
        close_out();
    end
endmodule
